// >>> hdl/flash_write_lock_key.sv
// Purpose: flash write/erase lock-and-key register block
// Assumes: processor register port with one-cycle read and write strobes
// Notes: flash op start is blocked unless the lock is open
`timescale 1ns/1ns
module flash_write_lock_key
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire flash_lock_pkg::reg_req_t req,
    output logic [7:0] rdata_q,
    output logic rvalid_q,
    // flash controller
    input wire logic op_req,
    input wire logic op_done,
    output logic op_go_q,
    output logic op_blocked_q,
    // status
    output logic grant_q,
    output logic [1:0] lock_state_q
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    flash_lock_pkg::lock_state_t state;
    flash_lock_pkg::flash_op_t op;
    wire logic hit = req.addr == flash_lock_pkg::flash_lock_key_addr;
    wire logic key_wr = req.wr && hit;
    wire logic rd_hit = req.rd && hit;
    wire logic [7:0] read_word = {6'h00, state};
    wire logic go = op_req && state == flash_lock_pkg::lock_open;

    assign op = '{start: op_req, done: op_done};

    lock_fsm u_fsm
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .key_wr(key_wr),
        .key_val(req.wdata),
        .op(op),
        .state_q(state),
        .grant_q(grant_q)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdata_q <= flash_lock_pkg::flash_lock_key_reset;
            rvalid_q <= 1'b0;
            op_go_q <= 1'b0;
            op_blocked_q <= 1'b0;
            lock_state_q <= flash_lock_pkg::lock_locked;
        end
        else if (ce)
        begin
            rvalid_q <= rd_hit;
            if (rd_hit)
                rdata_q <= read_word;
            op_go_q <= go;
            op_blocked_q <= op_req && !go;
            lock_state_q <= state;
        end
    end

    // ------------------------------------------------------------
    // checks: key sequence and reset
    // ------------------------------------------------------------
    property p_first_key;
        @(posedge clk_sys) disable iff (rst)
        ce && key_wr && !op_req && req.wdata == flash_lock_pkg::key_first
        && state == flash_lock_pkg::lock_locked
        |=> state == flash_lock_pkg::lock_first_ok;
    endproperty
    a_first_key: assert property (p_first_key)
        else $error("first key not accepted");

    property p_key_opens;
        @(posedge clk_sys) disable iff (rst)
        ce && key_wr && req.wdata == flash_lock_pkg::key_second && !op_req
        && state == flash_lock_pkg::lock_first_ok
        |=> state == flash_lock_pkg::lock_open;
    endproperty
    a_key_opens: assert property (p_key_opens)
        else $error("key pair did not open");

    property p_bad_first;
        @(posedge clk_sys) disable iff (rst)
        ce && key_wr && req.wdata != flash_lock_pkg::key_first
        && state == flash_lock_pkg::lock_locked
        |=> state == flash_lock_pkg::lock_dead;
    endproperty
    a_bad_first: assert property (p_bad_first)
        else $error("bad first key did not lock out");

    property p_bad_second;
        @(posedge clk_sys) disable iff (rst)
        ce && key_wr && req.wdata != flash_lock_pkg::key_second
        && state == flash_lock_pkg::lock_first_ok
        |=> state == flash_lock_pkg::lock_dead;
    endproperty
    a_bad_second: assert property (p_bad_second)
        else $error("bad second key did not lock out");

    // a key write while open is out of sequence, even a correct-looking one
    property p_key_while_open;
        @(posedge clk_sys) disable iff (rst)
        ce && key_wr && state == flash_lock_pkg::lock_open
        |=> state == flash_lock_pkg::lock_dead;
    endproperty
    a_key_while_open: assert property (p_key_while_open)
        else $error("key write while open did not lock out");

    property p_done_closes;
        @(posedge clk_sys) disable iff (rst)
        ce && op_done && !key_wr && state == flash_lock_pkg::lock_open
        |=> state == flash_lock_pkg::lock_locked;
    endproperty
    a_done_closes: assert property (p_done_closes)
        else $error("done did not close lock");

    property p_reset_locked;
        @(posedge clk_sys)
        rst |=> state == flash_lock_pkg::lock_locked;
    endproperty
    a_reset_locked: assert property (p_reset_locked)
        else $error("reset did not lock");

    property p_reset_outputs;
        @(posedge clk_sys)
        rst |=> !rvalid_q && !op_go_q && !op_blocked_q && !grant_q
        && lock_state_q == flash_lock_pkg::lock_locked;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("outputs not cleared by reset");

    // ------------------------------------------------------------
    // checks: flash operation gate
    // ------------------------------------------------------------
    // ce low freezes the pulse, so only judge it on the edge that made it
    property p_no_go_closed;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) && op_go_q |-> $past(state) == flash_lock_pkg::lock_open;
    endproperty
    a_no_go_closed: assert property (p_no_go_closed)
        else $error("op issued while closed");

    property p_go_when_open;
        @(posedge clk_sys) disable iff (rst)
        ce && op_req && state == flash_lock_pkg::lock_open
        |=> op_go_q && !op_blocked_q;
    endproperty
    a_go_when_open: assert property (p_go_when_open)
        else $error("op refused while open");

    property p_blocked_flag;
        @(posedge clk_sys) disable iff (rst)
        ce && op_req && state != flash_lock_pkg::lock_open
        |=> op_blocked_q && !op_go_q;
    endproperty
    a_blocked_flag: assert property (p_blocked_flag)
        else $error("op while closed not flagged as blocked");

    property p_idle_no_op;
        @(posedge clk_sys) disable iff (rst)
        ce && !op_req |=> !op_go_q && !op_blocked_q;
    endproperty
    a_idle_no_op: assert property (p_idle_no_op)
        else $error("op pulse without a request");

    // ------------------------------------------------------------
    // checks: register readback
    // ------------------------------------------------------------
    property p_readback;
        @(posedge clk_sys) disable iff (rst)
        ce && rd_hit |=> rvalid_q && rdata_q == {6'h00, $past(state)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback wrong");

    property p_no_stray_valid;
        @(posedge clk_sys) disable iff (rst)
        ce && !rd_hit |=> !rvalid_q;
    endproperty
    a_no_stray_valid: assert property (p_no_stray_valid)
        else $error("read valid without a key register read");

    // software may sample read data late, so it must not drift between reads
    property p_rdata_holds;
        @(posedge clk_sys) disable iff (rst)
        !(ce && rd_hit) |=> $stable(rdata_q);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data changed without a read");

    property p_state_mirror;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) && !$past(rst) |-> lock_state_q == $past(state);
    endproperty
    a_state_mirror: assert property (p_state_mirror)
        else $error("status copy does not follow lock state");

endmodule

// >>> hdl/flash_lock_pkg.sv
// Purpose: shared constants and types for the flash lock-and-key block
// Assumes: 8-bit special register space, one system clock
// Notes: lock state codes are the values read back in bits 1-0
package flash_lock_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] flash_lock_key_addr = 8'hb7;
    localparam logic [7:0] flash_lock_key_reset = 8'h00;

    // ------------------------------------------------------------
    // key values
    // ------------------------------------------------------------
    localparam logic [7:0] key_first = 8'ha5;
    localparam logic [7:0] key_second = 8'hf1;

    // ------------------------------------------------------------
    // lock state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        lock_locked = 2'b00,
        lock_first_ok = 2'b01,
        lock_open = 2'b10,
        lock_dead = 2'b11
    } lock_state_t;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed
    {
        logic start;
        logic done;
    } flash_op_t;

endpackage

// >>> hdl/lock_fsm.sv
// Purpose: lock-and-key state machine for flash write and erase permission
// Assumes: key writes and flash events are single-cycle pulses on clk_sys
// Notes: a flash start while not open blocks the op and kills the lock
`timescale 1ns/1ns
module lock_fsm
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // key write
    input wire logic key_wr,
    input wire logic [7:0] key_val,
    // flash operation
    input wire flash_lock_pkg::flash_op_t op,
    // state
    output flash_lock_pkg::lock_state_t state_q,
    output logic grant_q
);

    flash_lock_pkg::lock_state_t state_d;
    wire is_first = key_val == flash_lock_pkg::key_first;
    wire is_second = key_val == flash_lock_pkg::key_second;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            flash_lock_pkg::lock_locked:
            begin
                if (op.start)
                    state_d = flash_lock_pkg::lock_dead;
                else if (key_wr)
                    state_d = is_first ? flash_lock_pkg::lock_first_ok
                                       : flash_lock_pkg::lock_dead;
            end
            flash_lock_pkg::lock_first_ok:
            begin
                if (op.start)
                    state_d = flash_lock_pkg::lock_dead;
                else if (key_wr)
                    state_d = is_second ? flash_lock_pkg::lock_open
                                        : flash_lock_pkg::lock_dead;
            end
            flash_lock_pkg::lock_open:
            begin
                // any further key write while open departs from the sequence
                if (key_wr)
                    state_d = flash_lock_pkg::lock_dead;
                else if (op.done)
                    state_d = flash_lock_pkg::lock_locked;
            end
            flash_lock_pkg::lock_dead:
                state_d = flash_lock_pkg::lock_dead;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= flash_lock_pkg::lock_locked;
            grant_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            grant_q <= state_d == flash_lock_pkg::lock_open;
        end
    end

    property p_dead_sticks;
        @(posedge clk_sys) disable iff (rst)
        state_q == flash_lock_pkg::lock_dead |=> state_q == flash_lock_pkg::lock_dead;
    endproperty
    a_dead_sticks: assert property (p_dead_sticks)
        else $error("lockout left without reset");

    property p_blocked_start;
        @(posedge clk_sys) disable iff (rst)
        ce && op.start && state_q != flash_lock_pkg::lock_open
        |=> state_q == flash_lock_pkg::lock_dead;
    endproperty
    a_blocked_start: assert property (p_blocked_start)
        else $error("start while locked did not lock out");

endmodule

// >>> test/flash_write_lock_key_tb.sv
// Purpose: self-checking bench for the flash write lock-and-key block
// Assumes: fixed read and op latencies of one cycle
// Notes: expected lock state is tracked by bench functions and tasks, and set directly once in the scenarios
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module flash_write_lock_key_tb;
    logic clk_sys;
    logic rst;
    logic ce;
    flash_lock_pkg::reg_req_t req;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic op_req;
    logic op_done;
    logic op_go_q;
    logic op_blocked_q;
    logic grant_q;
    logic [1:0] lock_state_q;
    logic [1:0] exp;
    logic [31:0] rnd;
    int err_total = 0;
    int n_tests = 0;

    flash_write_lock_key uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req),
        .rdata_q(rdata_q), .rvalid_q(rvalid_q), .op_req(op_req), .op_done(op_done),
        .op_go_q(op_go_q), .op_blocked_q(op_blocked_q), .grant_q(grant_q),
        .lock_state_q(lock_state_q));

    // ------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function logic [1:0] nk(input logic [1:0] s, input logic [7:0] k);
        case (s)
            2'b00: nk = (k == flash_lock_pkg::key_first) ? 2'b01 : 2'b11;
            2'b01: nk = (k == flash_lock_pkg::key_second) ? 2'b10 : 2'b11;
            default: nk = 2'b11;
        endcase
    endfunction

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task step;
        @(posedge clk_sys);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        step;
        req.wr = 1'b0;
        if (ce && a == flash_lock_pkg::flash_lock_key_addr)
            exp = nk(exp, d);
        step;
    endtask

    task rchk(input logic [7:0] a);
        req.rd = 1'b1;
        req.addr = a;
        step;
        req.rd = 1'b0;
        `CHK(rvalid_q, (a == flash_lock_pkg::flash_lock_key_addr))
        if (rvalid_q === 1'b1)
            `CHK(rdata_q, {6'h00, exp})
        `CHK(grant_q, (exp == 2'b10))
        `CHK(lock_state_q, exp)
        step;
    endtask

    task op;
        logic open;
        open = (exp == 2'b10);
        op_req = 1'b1;
        step;
        op_req = 1'b0;
        `CHK({op_go_q, op_blocked_q}, {open, !open})
        exp = open ? exp : 2'b11;
        step;
        if (open)
        begin
            op_done = 1'b1;
            step;
            op_done = 1'b0;
            exp = 2'b00;
            step;
        end
        rchk(flash_lock_pkg::flash_lock_key_addr);
    endtask

    task rst_dut;
        rst = 1'b1;
        repeat (10) step;
        rst = 1'b0;
        exp = 2'b00;
        rchk(flash_lock_pkg::flash_lock_key_addr);
    endtask

    task tally_and_finish;
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // scenarios: corners first, then random traffic
    // ------------------------------------------------------------
    initial
    begin
        {rst, ce, req, op_req, op_done} = '0;
        ce = 1'b1;
        rnd = 32'haa52;
        rst_dut;
        op_done = 1'b1;
        step;
        op_done = 1'b0;
        step;
        rchk(8'hb7);
        wr(8'hb6, 8'h00);
        rchk(8'hb6);
        `CHK(rdata_q, 8'h00)
        wr(8'hb7, 8'ha5);
        rchk(8'hb7);
        ce = 1'b0;
        wr(8'hb7, 8'h00);
        ce = 1'b1;
        wr(8'hb7, 8'hf1);
        rchk(8'hb7);
        op;
        wr(8'hb7, 8'h00);
        op;
        rst_dut;
        op;
        rst_dut;
        req.wr = 1'b1;
        req.addr = 8'hb7;
        req.wdata = 8'ha5;
        op_req = 1'b1;
        step;
        req.wr = 1'b0;
        op_req = 1'b0;
        exp = 2'b11;
        `CHK({op_go_q, op_blocked_q}, 2'b01)
        step;
        rchk(8'hb7);
        rst_dut;
        wr(8'hb7, 8'ha5);
        wr(8'hb7, 8'ha5);
        rchk(8'hb7);
        rst_dut;
        repeat (60)
        begin
            rnd = lfsr(rnd);
            case (rnd[1:0])
                2'b00: wr(8'hb7, 8'ha5);
                2'b01: wr(8'hb7, 8'hf1);
                2'b10: wr(8'hb7, rnd[15:8]);
                default: op;
            endcase
            rchk(8'hb7);
            if (exp == 2'b11 && rnd[4])
                rst_dut;
        end
        tally_and_finish;
    end
endmodule
